// File: design/rcs_startup.sv
// reset and clock startup sequencer with axi4-lite register slave
// assumes inputs synchronous to mclk_in, which is the input clock of the device
//
// Function
// - ratio strap 00/01/10 gives core clock 8:1, 32:1, 16:1; 11 reserved
// - software may rewrite pll multiplier and divider anytime after reset
// - after reset release wait 4096 input clock cycles for pll lock
// - after lock wait, core starts fetching at the hardware reset vector
// - while reset input is low all state returns to known values
// - shared reset pin is a reset output by default
// - writing one to running reset control bit 0 makes pin an input
`timescale 1ns/1ns
`default_nettype none
module rcs_startup
#(
  parameter int unsigned LOCK_CYCLES = rcs_pkg::RCS_LOCK_CYCLES,
  parameter logic [31:0] RESET_VECTOR = 32'h0009_0000
)
(
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // straps
  input wire logic [1:0] clk_ratio_strap_in,
  input wire logic [2:0] boot_cfg_strap_in,
  // shared reset output / running reset input pin
  input wire logic reset_output_pin_in,
  output logic reset_output_pin_out,
  output logic reset_output_pin_oe_out,
  // core side
  output logic core_rst_n_out,
  output logic fetch_start_out,
  output logic [31:0] reset_vector_out,
  output logic [rcs_pkg::RCS_PM_MULT_W-1:0] pll_mult_out,
  output logic [rcs_pkg::RCS_PM_DIV_W-1:0] pll_div_out,
  output logic [2:0] boot_mode_out,
  // axi4-lite slave
  input wire logic [rcs_pkg::RCS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rcs_pkg::RCS_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rcs_pkg::RCS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rcs_pkg::RCS_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rcs_pkg::*;

  rcs_regs_t r_ff;
  rcs_regs_t nxt_r;
  logic lock_busy;
  logic lock_done;
  logic wr_go;
  logic [RCS_DATA_W-1:0] pm_word;
  logic [RCS_DATA_W-1:0] rr_word;
  logic [RCS_DATA_W-1:0] st_word;

  //////////////////////////////////////////////////////////////////////////////
  // lock wait timer

  rcs_lock_timer #(.LOCK_CYCLES(LOCK_CYCLES)) rcs_lock_timer_inst
  (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .start_in(r_ff.st == RCS_ST_CAPTURE),
    .busy_out(lock_busy),
    .done_out(lock_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register views

  always_comb
  begin
    pm_word = '0;
    pm_word[RCS_PM_MULT_LSB +: RCS_PM_MULT_W] = r_ff.mult;
    pm_word[RCS_PM_DIV_LSB +: RCS_PM_DIV_W] = r_ff.div;
    rr_word = '0;
    rr_word[RCS_RR_MODE_BIT] = r_ff.run_in_mode;
    st_word = '0;
    st_word[RCS_ST_RATIO_LSB +: 2] = r_ff.ratio;
    st_word[RCS_ST_BOOT_LSB +: 3] = r_ff.boot;
    st_word[RCS_ST_STATE_LSB +: 2] = r_ff.st;
    st_word[RCS_ST_RSVD_BIT] = (r_ff.ratio == RCS_RATIO_RSVD);
    st_word[RCS_ST_BUSY_BIT] = lock_busy;
  end

  assign wr_go = r_ff.aw_held && r_ff.w_held && !r_ff.bvalid;

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [RCS_DATA_W-1:0] pm_wr;
    logic [RCS_DATA_W-1:0] rr_wr;
    pm_wr = '0;
    rr_wr = '0;
    nxt_r = r_ff;
    nxt_r.fetch = 1'b0;
    // sequencer
    unique case (r_ff.st)
      RCS_ST_CAPTURE:
      begin
        nxt_r.ratio = clk_ratio_strap_in;
        nxt_r.boot = boot_cfg_strap_in;
        nxt_r.mult = rcs_strap_mult(clk_ratio_strap_in);
        nxt_r.div = RCS_DIV_RST;
        nxt_r.st = RCS_ST_LOCK;
      end
      RCS_ST_LOCK:
      begin
        if (lock_done)
        begin
          nxt_r.st = RCS_ST_RUN;
          nxt_r.fetch = 1'b1;
        end
      end
      RCS_ST_RUN:
      begin
        if (r_ff.run_in_mode && !reset_output_pin_in)
        begin
          nxt_r.st = RCS_ST_RUNRST;
        end
      end
      RCS_ST_RUNRST:
      begin
        // running reset restarts the core without a new lock wait
        if (reset_output_pin_in || !r_ff.run_in_mode)
        begin
          nxt_r.st = RCS_ST_RUN;
          nxt_r.fetch = 1'b1;
        end
      end
    endcase
    // write channel
    if (!r_ff.aw_held && s_axi_awvalid)
    begin
      nxt_r.aw_held = 1'b1;
      nxt_r.awaddr = s_axi_awaddr;
    end
    if (!r_ff.w_held && s_axi_wvalid)
    begin
      nxt_r.w_held = 1'b1;
      nxt_r.wdata = s_axi_wdata;
      nxt_r.wstrb = s_axi_wstrb;
    end
    if (wr_go)
    begin
      nxt_r.aw_held = 1'b0;
      nxt_r.w_held = 1'b0;
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp = RCS_RESP_OKAY;
      if (r_ff.awaddr == RCS_OFS_PWR_CTRL)
      begin
        if (r_ff.st != RCS_ST_CAPTURE)
        begin
          pm_wr = rcs_merge(pm_word, r_ff.wdata, r_ff.wstrb);
          nxt_r.mult = pm_wr[RCS_PM_MULT_LSB +: RCS_PM_MULT_W];
          nxt_r.div = pm_wr[RCS_PM_DIV_LSB +: RCS_PM_DIV_W];
        end
      end
      else if (r_ff.awaddr == RCS_OFS_RRCTL)
      begin
        rr_wr = rcs_merge(rr_word, r_ff.wdata, r_ff.wstrb);
        nxt_r.run_in_mode = rr_wr[RCS_RR_MODE_BIT];
      end
      else if (r_ff.awaddr != RCS_OFS_STAT)
      begin
        nxt_r.bresp = RCS_RESP_SLVERR;
      end
    end
    else if (r_ff.bvalid && s_axi_bready)
    begin
      nxt_r.bvalid = 1'b0;
    end
    // read channel
    if (!r_ff.rvalid && s_axi_arvalid)
    begin
      nxt_r.rvalid = 1'b1;
      nxt_r.rresp = RCS_RESP_OKAY;
      nxt_r.rdata = '0;
      if (s_axi_araddr == RCS_OFS_PWR_CTRL)
      begin
        nxt_r.rdata = pm_word;
      end
      else if (s_axi_araddr == RCS_OFS_RRCTL)
      begin
        nxt_r.rdata = rr_word;
      end
      else if (s_axi_araddr == RCS_OFS_STAT)
      begin
        nxt_r.rdata = st_word;
      end
      else
      begin
        nxt_r.rresp = RCS_RESP_SLVERR;
      end
    end
    else if (r_ff.rvalid && s_axi_rready)
    begin
      nxt_r.rvalid = 1'b0;
    end
    // shared pin: low while reset or lock wait, driven high in run, released to an input only in input mode
    nxt_r.pin_oe = !nxt_r.run_in_mode;
    nxt_r.pin_out = (nxt_r.st == RCS_ST_RUN) || (nxt_r.st == RCS_ST_RUNRST);
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      r_ff <= '0;
      r_ff.mult <= RCS_MULT_8;
      r_ff.div <= RCS_DIV_RST;
      r_ff.pin_oe <= 1'b1;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign core_rst_n_out = (r_ff.st == RCS_ST_RUN);
  assign fetch_start_out = r_ff.fetch;
  assign reset_vector_out = RESET_VECTOR;
  assign pll_mult_out = r_ff.mult;
  assign pll_div_out = r_ff.div;
  assign boot_mode_out = r_ff.boot;
  assign reset_output_pin_out = r_ff.pin_out;
  assign reset_output_pin_oe_out = r_ff.pin_oe;
  assign s_axi_awready = !r_ff.aw_held;
  assign s_axi_wready = !r_ff.w_held;
  assign s_axi_bvalid = r_ff.bvalid;
  assign s_axi_bresp = r_ff.bresp;
  assign s_axi_arready = !r_ff.rvalid;
  assign s_axi_rvalid = r_ff.rvalid;
  assign s_axi_rdata = r_ff.rdata;
  assign s_axi_rresp = r_ff.rresp;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  logic [31:0] lock_age_ff;
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      lock_age_ff <= '0;
    end
    else if (r_ff.st == RCS_ST_LOCK)
    begin
      lock_age_ff <= lock_age_ff + 32'h1;
    end
    else
    begin
      lock_age_ff <= '0;
    end
  end

  sequence s_leave_lock;
    (r_ff.st == RCS_ST_LOCK) ##1 (r_ff.st == RCS_ST_RUN);
  endsequence

  property p_ratio_init;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (r_ff.st == RCS_ST_CAPTURE) && arst_n_in
      |=> (pll_mult_out == rcs_strap_mult($past(clk_ratio_strap_in)));
  endproperty
  a_ratio_init: assert property (p_ratio_init) else $error("startup ratio wrong");

  property p_pm_write;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (wr_go && r_ff.awaddr == RCS_OFS_PWR_CTRL && r_ff.wstrb[0] && r_ff.st != RCS_ST_CAPTURE)
      |=> (pll_mult_out == $past(r_ff.wdata[7:0])) && s_axi_bvalid;
  endproperty
  a_pm_write: assert property (p_pm_write) else $error("multiplier write lost");

  property p_lock_len;
    @(posedge mclk_in) disable iff (!arst_n_in)
    s_leave_lock |-> ($past(lock_age_ff) == LOCK_CYCLES - 1);
  endproperty
  a_lock_len: assert property (p_lock_len) else $error("lock wait length wrong");

  property p_fetch;
    @(posedge mclk_in) disable iff (!arst_n_in)
    s_leave_lock |-> fetch_start_out && core_rst_n_out ##1 !fetch_start_out;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not started after lock");

  property p_reset_state;
    @(posedge mclk_in) disable iff (!arst_n_in)
    $rose(arst_n_in) |-> (r_ff.st == RCS_ST_CAPTURE) && !core_rst_n_out && reset_output_pin_oe_out;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("state not reset");

  property p_pin_default;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (r_ff.st == RCS_ST_CAPTURE) |-> reset_output_pin_oe_out && !reset_output_pin_out;
  endproperty
  a_pin_default: assert property (p_pin_default) else $error("pin not reset output");

  property p_rr_mode;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (wr_go && r_ff.awaddr == RCS_OFS_RRCTL && r_ff.wstrb[0] && r_ff.wdata[0])
      |=> !reset_output_pin_oe_out [*2];
  endproperty
  a_rr_mode: assert property (p_rr_mode) else $error("pin not switched to input");

  property p_straps_held;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (r_ff.st != RCS_ST_CAPTURE) |=> $stable(r_ff.ratio) && $stable(boot_mode_out);
  endproperty
  a_straps_held: assert property (p_straps_held) else $error("strap capture changed");

  property p_pin_low_lock;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (r_ff.st == RCS_ST_LOCK) |-> !reset_output_pin_out && !core_rst_n_out;
  endproperty
  a_pin_low_lock: assert property (p_pin_low_lock) else $error("reset out released early");

endmodule
`default_nettype wire

// File: design/rcs_pkg.sv
// reset and clock startup package: register map, field layout, states, strap decode
// assumes a 32-bit axi4-lite register bus and a single input clock
package rcs_pkg;

  localparam int unsigned RCS_ADDR_W = 8;
  localparam int unsigned RCS_DATA_W = 32;

  // register byte offsets
  localparam logic [RCS_ADDR_W-1:0] RCS_OFS_PWR_CTRL = 8'h00;
  localparam logic [RCS_ADDR_W-1:0] RCS_OFS_RRCTL = 8'h04;
  localparam logic [RCS_ADDR_W-1:0] RCS_OFS_STAT = 8'h08;

  // power management control fields
  localparam int unsigned RCS_PM_MULT_LSB = 0;
  localparam int unsigned RCS_PM_MULT_W = 8;
  localparam int unsigned RCS_PM_DIV_LSB = 8;
  localparam int unsigned RCS_PM_DIV_W = 4;
  // running reset control field
  localparam int unsigned RCS_RR_MODE_BIT = 0;
  // status fields
  localparam int unsigned RCS_ST_RATIO_LSB = 0;
  localparam int unsigned RCS_ST_BOOT_LSB = 2;
  localparam int unsigned RCS_ST_STATE_LSB = 5;
  localparam int unsigned RCS_ST_RSVD_BIT = 7;
  localparam int unsigned RCS_ST_BUSY_BIT = 8;

  // strap codes and the ratios they give
  localparam logic [1:0] RCS_RATIO_8 = 2'h0;
  localparam logic [1:0] RCS_RATIO_32 = 2'h1;
  localparam logic [1:0] RCS_RATIO_16 = 2'h2;
  localparam logic [1:0] RCS_RATIO_RSVD = 2'h3;
  localparam logic [RCS_PM_MULT_W-1:0] RCS_MULT_8 = 8'h08;
  localparam logic [RCS_PM_MULT_W-1:0] RCS_MULT_16 = 8'h10;
  localparam logic [RCS_PM_MULT_W-1:0] RCS_MULT_32 = 8'h20;
  localparam logic [RCS_PM_DIV_W-1:0] RCS_DIV_RST = 4'h1;

  // pll lock wait in input clock cycles
  localparam int unsigned RCS_LOCK_CYCLES = 4096;

  localparam logic [1:0] RCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] RCS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    RCS_ST_CAPTURE = 2'b00,
    RCS_ST_LOCK = 2'b01,
    RCS_ST_RUN = 2'b10,
    RCS_ST_RUNRST = 2'b11
  } rcs_state_t;

  typedef struct packed
  {
    rcs_state_t st;
    logic [1:0] ratio;
    logic [2:0] boot;
    logic [RCS_PM_MULT_W-1:0] mult;
    logic [RCS_PM_DIV_W-1:0] div;
    logic run_in_mode;
    logic fetch;
    logic pin_out;
    logic pin_oe;
    logic aw_held;
    logic [RCS_ADDR_W-1:0] awaddr;
    logic w_held;
    logic [RCS_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [RCS_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } rcs_regs_t;

  // startup multiplier chosen by the ratio strap; reserved code falls back to 8:1
  function automatic logic [RCS_PM_MULT_W-1:0] rcs_strap_mult(input logic [1:0] code);
    logic [RCS_PM_MULT_W-1:0] m;
    m = RCS_MULT_8;
    if (code == RCS_RATIO_32)
    begin
      m = RCS_MULT_32;
    end
    else if (code == RCS_RATIO_16)
    begin
      m = RCS_MULT_16;
    end
    return m;
  endfunction

  // byte-lane merge of a write into an old register value
  function automatic logic [RCS_DATA_W-1:0] rcs_merge(input logic [RCS_DATA_W-1:0] old_v,
                                                      input logic [RCS_DATA_W-1:0] new_v,
                                                      input logic [3:0] strb);
    logic [RCS_DATA_W-1:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// File: design/rcs_lock_timer.sv
// pll lock wait timer: counts a fixed number of clock cycles after a start pulse
// assumes start_in is a one-cycle pulse from the startup sequencer
`timescale 1ns/1ns
`default_nettype none
module rcs_lock_timer
#(
  parameter int unsigned LOCK_CYCLES = rcs_pkg::RCS_LOCK_CYCLES
)
(
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);
  import rcs_pkg::*;

  localparam int unsigned CW = $clog2(LOCK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(LOCK_CYCLES - 1);

  typedef struct packed
  {
    logic busy;
    logic [CW-1:0] cnt;
  } rcs_tmr_t;

  rcs_tmr_t tmr_ff;
  rcs_tmr_t nxt_tmr;

  always_comb
  begin
    nxt_tmr = tmr_ff;
    if (start_in)
    begin
      nxt_tmr.busy = 1'b1;
      nxt_tmr.cnt = '0;
    end
    else if (tmr_ff.busy)
    begin
      nxt_tmr.cnt = tmr_ff.cnt + CW'(1);
      if (tmr_ff.cnt == LAST)
      begin
        nxt_tmr.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tmr_ff <= '0;
    end
    else
    begin
      tmr_ff <= nxt_tmr;
    end
  end

  assign busy_out = tmr_ff.busy;
  assign done_out = tmr_ff.busy && (tmr_ff.cnt == LAST);

  property p_tmr_done_once;
    @(posedge mclk_in) disable iff (!arst_n_in)
    done_out |=> !busy_out && !done_out;
  endproperty
  a_tmr_done_once: assert property (p_tmr_done_once) else $error("lock timer done not single");

endmodule
`default_nettype wire

// File: verif/rcs_board_model.sv
// board side of the startup block: reset source, strap wiring, pulled-up shared reset pin
// assumes bench requests change just after a rising edge of mclk_in
`timescale 1ns/1ns
`default_nettype none
module rcs_board_model
(
  input wire logic mclk_in,
  input wire logic rst_req_in,
  input wire logic [1:0] ratio_sel_in,
  input wire logic [2:0] boot_sel_in,
  input wire logic pull_low_in,
  input wire logic dev_pin_in,
  input wire logic dev_oe_in,
  output logic arst_n_out,
  output logic [1:0] clk_ratio_strap_out,
  output logic [2:0] boot_cfg_strap_out,
  output logic pin_level_out
);
  initial
  begin
    arst_n_out = 1'b0;
    clk_ratio_strap_out = 2'h0;
    boot_cfg_strap_out = 3'h0;
  end

  // straps and the reset request are all registered on the same rising edge of mclk_in
  always @(posedge mclk_in)
  begin
    clk_ratio_strap_out <= ratio_sel_in;
    boot_cfg_strap_out <= boot_sel_in;
    arst_n_out <= !rst_req_in;
  end

  // pull-up on the pin; the board pulls low only as a running reset request
  assign pin_level_out = dev_oe_in ? dev_pin_in : !pull_low_in;
endmodule
`default_nettype wire

// File: verif/reset_clock_startup_tb.sv
// self-checking bench for the startup sequencer and its register slave
// assumes rcs_pkg and the design files are compiled first
`timescale 1ns/1ns
`default_nettype none
module reset_clock_startup_tb;
  import rcs_pkg::*;
  localparam int unsigned LOCK = 8;
  localparam logic [31:0] VEC = 32'h0000_0a5c;
  logic mclk = 1'b0;
  logic rst_req = 1'b1;
  logic [1:0] ratio_sel = 2'h0;
  logic [2:0] boot_sel = 3'h0;
  logic pull_low = 1'b0;
  logic arst_n, pin_lvl, pin_out, pin_oe, core_rst_n, fetch;
  logic [1:0] ratio_strap;
  logic [2:0] boot_strap, boot_mode;
  logic [31:0] vector;
  logic [7:0] mult;
  logic [3:0] div;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d;
  int n_errors = 0;
  int comparisons = 0;
  int n;

  always #5 mclk = ~mclk;

  rcs_board_model rcs_board_model_inst (.mclk_in(mclk), .rst_req_in(rst_req),
    .ratio_sel_in(ratio_sel), .boot_sel_in(boot_sel), .pull_low_in(pull_low),
    .dev_pin_in(pin_out), .dev_oe_in(pin_oe), .arst_n_out(arst_n),
    .clk_ratio_strap_out(ratio_strap), .boot_cfg_strap_out(boot_strap),
    .pin_level_out(pin_lvl));

  rcs_startup #(.LOCK_CYCLES(LOCK), .RESET_VECTOR(VEC)) rcs_startup_inst (.mclk_in(mclk),
    .arst_n_in(arst_n), .clk_ratio_strap_in(ratio_strap), .boot_cfg_strap_in(boot_strap),
    .reset_output_pin_in(pin_lvl), .reset_output_pin_out(pin_out),
    .reset_output_pin_oe_out(pin_oe), .core_rst_n_out(core_rst_n),
    .fetch_start_out(fetch), .reset_vector_out(vector), .pll_mult_out(mult),
    .pll_div_out(div), .boot_mode_out(boot_mode), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ready and answer are looked at 1 ns after an edge, i.e. as the next edge samples them
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                           output logic [1:0] resp);
    logic ra, rw, rb, ad, wd, got;
    logic [1:0] rs;
    int cnt;
    ad = 0;
    wd = 0;
    got = 0;
    cnt = 0;
    resp = 2'h1;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got && cnt < 50)
    begin
      #1;
      ra = awready;
      rw = wready;
      rb = bvalid;
      rs = bresp;
      @(posedge mclk);
      cnt++;
      if (ra && !ad)
      begin
        awvalid <= 1'b0;
        ad = 1;
      end
      if (rw && !wd)
      begin
        wvalid <= 1'b0;
        wd = 1;
      end
      if (rb)
      begin
        resp = rs;
        got = 1;
        bready <= 1'b0;
      end
    end
    chk("write answer", 32'h1, 32'(got));
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ra, rv, ad, got;
    logic [1:0] rs;
    logic [31:0] rd;
    int cnt;
    ad = 0;
    got = 0;
    cnt = 0;
    v = 32'h0;
    resp = 2'h1;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got && cnt < 50)
    begin
      #1;
      ra = arready;
      rv = rvalid;
      rs = rresp;
      rd = rdata;
      @(posedge mclk);
      cnt++;
      if (ra && !ad)
      begin
        arvalid <= 1'b0;
        ad = 1;
      end
      if (rv)
      begin
        v = rd;
        resp = rs;
        got = 1;
        rready <= 1'b0;
      end
    end
    chk("read answer", 32'h1, 32'(got));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // reset with given straps, then time the lock wait and check the captured state
  task automatic boot_up(input logic [1:0] code, input logic [2:0] boot);
    logic held;
    logic [7:0] em;
    held = 1;
    em = (code == 2'h1) ? RCS_MULT_32 : (code == 2'h2) ? RCS_MULT_16 : RCS_MULT_8;
    @(posedge mclk);
    ratio_sel <= code;
    boot_sel <= boot;
    @(posedge mclk);
    rst_req <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    chk("core reset", 32'h0, 32'(core_rst_n));
    chk("pin oe", 32'h1, 32'(pin_oe));
    chk("pin out", 32'h0, 32'(pin_out));
    chk("mult at reset", 32'(RCS_MULT_8), 32'(mult));
    chk("div at reset", 32'(RCS_DIV_RST), 32'(div));
    chk("bvalid at reset", 32'h0, 32'(bvalid));
    @(posedge mclk);
    rst_req <= 1'b0;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
      if (core_rst_n !== 1'b1 && pin_out !== 1'b0) held = 0;
    end while (core_rst_n !== 1'b1 && n < 100);
    chk("lock wait", 32'(LOCK + 2), 32'(n));
    chk("reset out held", 32'h1, 32'(held));
    chk("fetch", 32'h1, 32'(fetch));
    chk("vector", VEC, vector);
    chk("mult", 32'(em), 32'(mult));
    chk("boot mode", 32'(boot), 32'(boot_mode));
    @(posedge mclk);
    ratio_sel <= ~code;
    boot_sel <= ~boot;
    #1;
    chk("fetch pulse", 32'h0, 32'(fetch));
    chk("pin out run", 32'h1, 32'(pin_out));
    repeat (3) @(posedge mclk);
    #1;
    chk("boot kept", 32'(boot), 32'(boot_mode));
    chk("mult kept", 32'(em), 32'(mult));
    axi_read(RCS_OFS_STAT, d, r);
    chk("status", {23'h0, 1'b0, code == RCS_RATIO_RSVD, RCS_ST_RUN, boot, code}, d);
  endtask

  initial
  begin
    for (int c = 0; c < 4; c++)
    begin
      boot_up(2'(c), 3'(c * 3 + 1));
    end
    axi_write(RCS_OFS_PWR_CTRL, 32'h0000_0537, 4'hf, r);
    chk("pwr ctrl resp", 32'(RCS_RESP_OKAY), 32'(r));
    repeat (2) @(posedge mclk);
    #1;
    chk("sw mult", 32'h37, 32'(mult));
    chk("sw div", 32'h5, 32'(div));
    axi_write(RCS_OFS_PWR_CTRL, 32'hffff_ff99, 4'h1, r);
    repeat (2) @(posedge mclk);
    #1;
    chk("lane mult", 32'h99, 32'(mult));
    chk("lane div", 32'h5, 32'(div));
    axi_read(RCS_OFS_PWR_CTRL, d, r);
    chk("pwr ctrl read", 32'h0000_0599, d);
    axi_read(8'h0c, d, r);
    chk("unmapped rresp", 32'(RCS_RESP_SLVERR), 32'(r));
    chk("unmapped rdata", 32'h0, d);
    axi_write(8'h10, 32'h1, 4'hf, r);
    chk("unmapped bresp", 32'(RCS_RESP_SLVERR), 32'(r));
    axi_write(RCS_OFS_RRCTL, 32'h1, 4'hf, r);
    repeat (2) @(posedge mclk);
    #1;
    chk("input mode oe", 32'h0, 32'(pin_oe));
    @(posedge mclk);
    pull_low <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk("running reset", 32'h0, 32'(core_rst_n));
    @(posedge mclk);
    pull_low <= 1'b0;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end while (fetch !== 1'b1 && n < 5);
    chk("rerun fetch", 32'h1, 32'(fetch));
    chk("rerun core", 32'h1, 32'(core_rst_n));
    axi_write(RCS_OFS_RRCTL, 32'h0, 4'hf, r);
    repeat (2) @(posedge mclk);
    #1;
    chk("output mode oe", 32'h1, 32'(pin_oe));
    boot_up(2'h2, 3'h5);
    test_done();
  end

  initial
  begin
    #50000;
    n_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    test_done();
  end
endmodule
`default_nettype wire
